// ==== itf_defines.svh ====
//Contract
// [R1] sample current and voltage 32 per cycle
// [R2] fixed current pickup, direction from sign
// [R3] detect pulses wider than fifth of interval
// [R4] one fault starts stage, adds 20 ms
// [R5] fault within intermittent time keeps delay count
// [R6] isolated fault releasing early never trips
// [R7] trip needs peaks, full delay, intermittent alive
// [R8] peaks 1-20, delay 0.04-300 s, intermittent 0-300 s
// [R9] reset delay 0.06-300 s holds trip
// [R10] delay timing starts at first peak
// [R11] full delay, too few peaks: release on expiry
// [R12] last peak after full delay trips at once
// [R13] intermittent expiry before full delay releases
// [R14] reject delay below peaks times 10 ms
// [R15] steady sine trips only above fundamental peak
// [R16] stage only with direct residual voltage
// [R17] block input stops the stage; ignored once tripped, trip held
// [R18] start output may block other stages
// [R19] keep eight latest fault records
// [R20] force flag clears after five minutes
// [R21] two setting groups, selectable source
// [R22] millisecond timebase from sampling tick
// [R23] state is idle, blocked, started or tripped
`ifndef ITF_DEFINES_SVH
`define ITF_DEFINES_SVH
`define ITF_SAMPLES_PER_CYCLE 32
`define ITF_SAMPLE_US_50 11'd625
`define ITF_SAMPLE_US_60 11'd520
`define ITF_US_PER_MS 11'd1000
`define ITF_PICKUP 16'h0400
`define ITF_FAULT_STEP_MS 19'd20
`define ITF_PEAK_GAP_MS 32'd10
`define ITF_PEAKS_MIN 32'd1
`define ITF_PEAKS_MAX 32'd20
`define ITF_OPDLY_MIN 32'd40
`define ITF_RSTDLY_MIN 32'd60
`define ITF_TIME_MAX 32'd300000
`define ITF_PCT_FULL 26'd100
`define ITF_FORCE_TIMEOUT_S 300
`define ITF_MS_PER_S 1000
`define ITF_C_EN 0
`define ITF_C_U0D 1
`define ITF_C_FORCE 2
`define ITF_C_GSRC 3
`define ITF_C_GMAN 4
`define ITF_C_F60 5
`define ITF_C_FSTART 6
`define ITF_C_FTRIP 7
`define ITF_CTRL_RST 8'h03
`define ITF_PEAKS_RST 5'd2
`define ITF_OPDLY_RST 19'd160
`define ITF_INTRMT_RST 19'd200
`define ITF_RSTDLY_RST 19'd60
`define ITF_A_CTRL 8'h00
`define ITF_A_STATUS 8'h04
`define ITF_A_U0PICK 8'h08
`define ITF_A_DELAY 8'h0C
`define ITF_A_RSEL 8'h10
`define ITF_A_RDATE 8'h14
`define ITF_A_RTIME 8'h18
`define ITF_A_RFLT 8'h1C
`define ITF_A_RINFO 8'h20
`define ITF_A_GRP 3'h2
`define ITF_G_PEAKS 2'h0
`define ITF_G_OPDLY 2'h1
`define ITF_G_INTRMT 2'h2
`define ITF_G_RSTDLY 2'h3
`endif

// ==== itf_pkg.sv ====
package itf_pkg;
   typedef enum logic [3:0] {
      ITF_IDLE = 4'h1,
      ITF_BLOCKED = 4'h2,
      ITF_STARTED = 4'h4,
      ITF_TRIPPED = 4'h8
   } itf_state_t;
   typedef struct packed {
      logic [31:0] date;
      logic [31:0] tod;
      logic [15:0] flt;
      logic [15:0] u0;
      logic [7:0] pct;
      logic grp;
   } itf_rec_t;
endpackage

// ==== itf_rec_if.sv ====
interface itf_rec_if;
   logic we;
   itf_pkg::itf_rec_t wdata;
   logic [2:0] rsel;
   itf_pkg::itf_rec_t rdata;
   logic rvalid;
   modport stage(output we, output wdata, output rsel, input rdata, input rvalid);
   modport log(input we, input wdata, input rsel, output rdata, output rvalid);
endinterface

// ==== itf_fault_log.sv ====
module itf_fault_log #(
   parameter int DEPTH = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   itf_rec_if.log rec
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW-1:0] wptr;
      logic [AW:0] cnt;
   } itf_log_t;
   itf_log_t s;
   itf_log_t next_s;
   itf_pkg::itf_rec_t mem [DEPTH];
   logic [AW-1:0] ridx;

   if (DEPTH != 8) begin : g_chk
      $error("fault log depth must be 8");
   end

   // ring pointer and fill count
   always_comb begin
      next_s = s;
      if (rec.we) begin
         next_s.wptr = AW'(s.wptr + 1'b1);
         if (s.cnt != (AW+1)'(DEPTH)) begin
            next_s.cnt = (AW+1)'(s.cnt + 1'b1);
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // record storage, oldest overwritten
   always_ff @(posedge pclk) begin
      if (rec.we) begin
         mem[s.wptr] <= rec.wdata; // [R19]
      end
   end

   // index 0 is the newest record
   assign ridx = AW'(s.wptr - 1'b1 - rec.rsel);
   assign rec.rdata = mem[ridx];
   assign rec.rvalid = ({1'b0, rec.rsel} < s.cnt);
endmodule

// ==== itf_transient_stage.sv ====
// The APB register port and the address map were left to the implementer.
`include "itf_defines.svh"
module itf_transient_stage #(
   parameter int SW = 16,
   parameter int FORCE_MS = `ITF_FORCE_TIMEOUT_S * `ITF_MS_PER_S
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire logic sample_valid,
   input wire logic signed [SW-1:0] residual_current,
   input wire logic signed [SW-1:0] residual_voltage,
   input wire logic [SW-1:0] fund_peak,
   input wire logic stage_block,
   input wire logic group_di,
   input wire logic [31:0] rtc_date,
   input wire logic [31:0] rtc_time,
   output logic stage_start,
   output logic stage_trip,
   output logic [3:0] stage_state
);
   typedef struct packed {
      logic [7:0] ctrl;
      logic [SW-1:0] u0_pick;
      logic [1:0][4:0] peaks;
      logic [1:0][18:0] opdly;
      logic [1:0][18:0] intrmt;
      logic [1:0][18:0] rstdly;
      itf_pkg::itf_state_t state;
      logic [10:0] us_acc;
      logic armed;
      logic [4:0] pcnt;
      logic [18:0] dly;
      logic [18:0] gap;
      logic [18:0] rst;
      logic [18:0] fms;
      logic [15:0] max_i;
      logic [15:0] max_u;
      logic err;
      logic [2:0] rsel;
      logic [31:0] prdata;
      logic di1;
      logic di2;
      logic start;
      logic trip;
   } itf_st_t;

   localparam itf_st_t ST_RST = '{
      ctrl: `ITF_CTRL_RST,
      peaks: {2{`ITF_PEAKS_RST}},
      opdly: {2{`ITF_OPDLY_RST}},
      intrmt: {2{`ITF_INTRMT_RST}},
      rstdly: {2{`ITF_RSTDLY_RST}},
      state: itf_pkg::ITF_IDLE,
      armed: 1'b1,
      default: '0
   };

   itf_st_t s;
   itf_st_t next_s;
   itf_rec_if rec ();
   logic g;
   logic en;
   logic tick;
   logic hit;
   logic pk;
   logic wr;
   logic ok;
   logic expd;
   logic rel;
   logic [10:0] acc;
   logic [SW-1:0] im;
   logic [SW-1:0] um;
   logic [19:0] dsum;
   logic [25:0] quo;

   if (SW < 8 || SW > 16) begin : g_chk_sw
      $error("sample width must be 8 to 16");
   end
   if (FORCE_MS < 1 || FORCE_MS >= (1 << 19)) begin : g_chk_force
      $error("force timeout out of range");
   end

   function automatic logic [SW-1:0] mag(input logic signed [SW-1:0] v);
      mag = v[SW-1] ? SW'(-v) : SW'(v);
   endfunction

   function automatic logic is_grp(input logic [7:0] a);
      is_grp = (a[7:5] == `ITF_A_GRP);
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a[1:0] == 2'h0) && (a <= `ITF_A_RINFO || is_grp(a));
   endfunction

   // next-state logic for timebase, detection, stage and bus
   always_comb begin
      next_s = s;
      rec.we = 1'b0;
      rel = 1'b0;
      ok = 1'b0;
      next_s.di1 = group_di;
      next_s.di2 = s.di1;
      g = s.ctrl[`ITF_C_GSRC] ? s.di2 : s.ctrl[`ITF_C_GMAN]; // [R21]
      en = s.ctrl[`ITF_C_EN] & s.ctrl[`ITF_C_U0D]; // [R16]
      // 1 ms tick from the sample rate, 32 samples per cycle
      acc = s.us_acc;
      tick = 1'b0;
      if (sample_valid) begin
         acc = s.us_acc + (s.ctrl[`ITF_C_F60] ? `ITF_SAMPLE_US_60 : `ITF_SAMPLE_US_50); // [R1]
         if (acc >= `ITF_US_PER_MS) begin
            acc = acc - `ITF_US_PER_MS; // [R22]
            tick = 1'b1;
         end
      end
      next_s.us_acc = acc;
      // one sample above fixed pickup counts, sign decides
      im = mag(residual_current);
      um = mag(residual_voltage);
      hit = sample_valid && (16'(im) > `ITF_PICKUP) // [R2] [R3]
         && (im > fund_peak) // [R15]
         && (um >= s.u0_pick)
         && (residual_current[SW-1] != residual_voltage[SW-1]); // [R2]
      if (sample_valid) begin
         next_s.armed = ~hit;
      end
      pk = hit & s.armed;
      expd = (s.gap > s.intrmt[g]);
      dsum = {1'b0, s.dly};
      // stage sequence
      case (s.state)
         itf_pkg::ITF_IDLE: begin
            if (en && stage_block) begin
               next_s.state = itf_pkg::ITF_BLOCKED; // [R17]
            end else if (en && pk) begin
               next_s.state = itf_pkg::ITF_STARTED; // [R4]
               next_s.pcnt = 5'd1;
               next_s.dly = `ITF_FAULT_STEP_MS; // [R10]
               next_s.gap = '0;
               next_s.max_i = 16'(im);
               next_s.max_u = 16'(um);
            end
         end
         itf_pkg::ITF_BLOCKED: begin
            if (!stage_block || !en) begin
               next_s.state = itf_pkg::ITF_IDLE; // [R17]
            end
         end
         itf_pkg::ITF_STARTED: begin
            if (tick) begin
               next_s.gap = 19'(s.gap + 1'b1);
               dsum = 20'(dsum + 1'b1); // [R10]
            end
            if (pk) begin
               // at least 20 ms per fault since the previous one
               if (s.gap < `ITF_FAULT_STEP_MS) begin
                  dsum = 20'(dsum + (`ITF_FAULT_STEP_MS - s.gap)); // [R4] [R5]
               end
               next_s.gap = '0;
               if (s.pcnt != 5'h1F) begin
                  next_s.pcnt = 5'(s.pcnt + 1'b1);
               end
               if (16'(im) > s.max_i) begin
                  next_s.max_i = 16'(im);
               end
               if (16'(um) > s.max_u) begin
                  next_s.max_u = 16'(um);
               end
            end
            if (dsum > {1'b0, s.opdly[g]}) begin
               dsum = {1'b0, s.opdly[g]};
            end
            next_s.dly = dsum[18:0];
            if (!en || stage_block) begin
               next_s.state = en ? itf_pkg::ITF_BLOCKED : itf_pkg::ITF_IDLE;
               rel = 1'b1;
            end else if (next_s.pcnt >= s.peaks[g]
                  && next_s.dly >= s.opdly[g]
                  && (pk || !expd)) begin
               next_s.state = itf_pkg::ITF_TRIPPED; // [R7] [R12]
               next_s.rst = '0;
            end else if (expd) begin
               next_s.state = itf_pkg::ITF_IDLE; // [R6] [R11] [R13]
               rel = 1'b1;
            end
         end
         itf_pkg::ITF_TRIPPED: begin
            // trip held for the reset delay once the intermittent time has expired after the last fault
            if (pk) begin
               next_s.gap = '0;
               next_s.rst = '0;
            end else if (tick) begin
               if (!expd) begin
                  next_s.gap = 19'(s.gap + 1'b1);
               end else begin
                  next_s.rst = 19'(s.rst + 1'b1); // [R9]
               end
            end
            if (!en || (expd && s.rst >= s.rstdly[g])) begin
               next_s.state = itf_pkg::ITF_IDLE; // [R9]
               rel = 1'b1;
            end
         end
         default: begin
            next_s.state = itf_pkg::ITF_IDLE;
         end
      endcase
      if (next_s.state != itf_pkg::ITF_STARTED && next_s.state != itf_pkg::ITF_TRIPPED) begin
         next_s.pcnt = '0;
         next_s.dly = '0;
         next_s.gap = '0;
         next_s.rst = '0;
      end
      // fault record at release, percent of operation delay
      quo = ({7'h0, s.dly} * `ITF_PCT_FULL) / {7'h0, s.opdly[g]};
      if (s.state == itf_pkg::ITF_TRIPPED || quo > `ITF_PCT_FULL) begin
         quo = `ITF_PCT_FULL;
      end
      rec.we = rel; // [R19]
      rec.wdata = '{date: rtc_date, tod: rtc_time, flt: s.max_i, u0: s.max_u,
         pct: quo[7:0], grp: g};
      // force flag drops itself after the timeout
      if (s.ctrl[`ITF_C_FORCE]) begin
         if (tick) begin
            next_s.fms = 19'(s.fms + 1'b1);
         end
         if (s.fms >= 19'(FORCE_MS)) begin
            next_s.ctrl[`ITF_C_FORCE] = 1'b0; // [R20]
            next_s.ctrl[`ITF_C_FSTART] = 1'b0;
            next_s.ctrl[`ITF_C_FTRIP] = 1'b0;
            next_s.fms = '0;
         end
      end else begin
         next_s.fms = '0;
      end
      // apb writes take effect in the access phase
      wr = psel & penable & pwrite & mapped(paddr);
      if (wr) begin
         case (paddr)
            `ITF_A_CTRL: begin
               next_s.ctrl = pwdata[7:0];
               next_s.fms = '0;
            end
            `ITF_A_STATUS: begin
               next_s.err = 1'b0;
            end
            `ITF_A_U0PICK: begin
               next_s.u0_pick = pwdata[SW-1:0];
            end
            `ITF_A_RSEL: begin
               next_s.rsel = pwdata[2:0];
            end
            default: begin
               if (is_grp(paddr)) begin
                  case (paddr[3:2])
                     `ITF_G_PEAKS: begin
                        ok = pwdata >= `ITF_PEAKS_MIN && pwdata <= `ITF_PEAKS_MAX // [R8]
                           && {13'h0, s.opdly[paddr[4]]} >= pwdata * `ITF_PEAK_GAP_MS; // [R14]
                        if (ok) begin
                           next_s.peaks[paddr[4]] = pwdata[4:0];
                        end
                     end
                     `ITF_G_OPDLY: begin
                        ok = pwdata >= `ITF_OPDLY_MIN && pwdata <= `ITF_TIME_MAX // [R8]
                           && pwdata >= {27'h0, s.peaks[paddr[4]]} * `ITF_PEAK_GAP_MS; // [R14]
                        if (ok) begin
                           next_s.opdly[paddr[4]] = pwdata[18:0];
                        end
                     end
                     `ITF_G_INTRMT: begin
                        ok = pwdata <= `ITF_TIME_MAX; // [R8]
                        if (ok) begin
                           next_s.intrmt[paddr[4]] = pwdata[18:0];
                        end
                     end
                     default: begin
                        ok = pwdata >= `ITF_RSTDLY_MIN && pwdata <= `ITF_TIME_MAX; // [R9]
                        if (ok) begin
                           next_s.rstdly[paddr[4]] = pwdata[18:0];
                        end
                     end
                  endcase
                  if (!ok) begin
                     next_s.err = 1'b1; // [R14]
                  end
               end
            end
         endcase
      end
      // read data captured in the setup phase
      if (psel && !penable) begin
         case (paddr)
            `ITF_A_CTRL: next_s.prdata = {24'h0, s.ctrl};
            `ITF_A_STATUS: next_s.prdata = {21'h0, s.pcnt, g, s.err, s.state}; // [R23]
            `ITF_A_U0PICK: next_s.prdata = 32'(s.u0_pick);
            `ITF_A_DELAY: next_s.prdata = {13'h0, s.dly};
            `ITF_A_RSEL: next_s.prdata = {29'h0, s.rsel};
            `ITF_A_RDATE: next_s.prdata = rec.rdata.date;
            `ITF_A_RTIME: next_s.prdata = rec.rdata.tod;
            `ITF_A_RFLT: next_s.prdata = {rec.rdata.u0, rec.rdata.flt};
            `ITF_A_RINFO: next_s.prdata = {22'h0, rec.rvalid, rec.rdata.grp, rec.rdata.pct};
            default: begin
               next_s.prdata = '0;
               if (is_grp(paddr)) begin
                  case (paddr[3:2])
                     `ITF_G_PEAKS: next_s.prdata = {27'h0, s.peaks[paddr[4]]};
                     `ITF_G_OPDLY: next_s.prdata = {13'h0, s.opdly[paddr[4]]};
                     `ITF_G_INTRMT: next_s.prdata = {13'h0, s.intrmt[paddr[4]]};
                     default: next_s.prdata = {13'h0, s.rstdly[paddr[4]]};
                  endcase
               end
            end
         endcase
      end
      // registered stage outputs, forcing only with the flag on
      next_s.start = next_s.state == itf_pkg::ITF_STARTED // [R4]
         || next_s.state == itf_pkg::ITF_TRIPPED
         || (next_s.ctrl[`ITF_C_FORCE] && next_s.ctrl[`ITF_C_FSTART]); // [R20]
      next_s.trip = next_s.state == itf_pkg::ITF_TRIPPED
         || (next_s.ctrl[`ITF_C_FORCE] && next_s.ctrl[`ITF_C_FTRIP]);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= ST_RST;
      end else begin
         s <= next_s;
      end
   end

   itf_fault_log #(.DEPTH(8)) u_log (
      .pclk(pclk),
      .presetn(presetn),
      .rec(rec.log)
   );

   // bus answers and stage outputs
   assign rec.rsel = s.rsel;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped(paddr);
   assign prdata = s.prdata;
   assign stage_start = s.start;
   assign stage_trip = s.trip;
   assign stage_state = s.state; // [R23]
endmodule

// ==== itf_props.sv ====
module itf_stage_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic sample_valid,
   input wire logic stage_block,
   input wire logic stage_start,
   input wire logic stage_trip,
   input wire logic [3:0] stage_state
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // holes in the register map
   logic hole;
   assign hole = (paddr[1:0] != 2'h0) || (paddr inside {[8'h24:8'h3F]}) || (paddr >= 8'h60);
   // start needs a sample, a bus write or a block release just before
   sequence cause_s;
      $past(sample_valid) || $past(sample_valid, 2) || $past(psel) || $past(psel, 2)
         || $past(stage_block) || $past(stage_block, 2);
   endsequence
   chk_ready_high: assert property (pready)
      else $error("pready low");
   chk_slverr_hole: assert property (psel && penable && hole |-> pslverr)
      else $error("no slverr on hole");
   chk_slverr_idle: assert property (!(psel && penable) |-> !pslverr)
      else $error("slverr outside access");
   chk_state_onehot: assert property ($onehot(stage_state))
      else $error("state not one-hot");
   // forcing may raise start on its own, so only the state side is tied
   chk_start_level: assert property ((stage_state[2] | stage_state[3]) |-> stage_start)
      else $error("start low while started");
   chk_trip_state: assert property (stage_state == 4'h8 |-> stage_trip)
      else $error("trip low while tripped");
   chk_trip_start: assert property (stage_trip |-> stage_start)
      else $error("trip without start");
   chk_idle_quiet: assert property (stage_state == 4'h1 |-> !stage_trip)
      else $error("trip while idle");
   chk_block_state: assert property (stage_block && stage_state == 4'h1
      |-> ##[1:2] stage_state == 4'h2)
      else $error("block ignored");
   chk_start_cause: assert property ($rose(stage_start) |-> cause_s)
      else $error("start without cause");
   chk_reset_idle: assert property (!$past(presetn) |-> stage_state == 4'h1 && !stage_start)
      else $error("not idle after reset");
   cover property ($rose(stage_start));
   cover property ($rose(stage_trip));
   cover property (stage_state == 4'h2);
   cover property (pslverr);
endmodule

bind itf_transient_stage itf_stage_chk u_itf_stage_chk (.pclk(pclk), .presetn(presetn),
   .paddr(paddr), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
   .sample_valid(sample_valid), .stage_block(stage_block), .stage_start(stage_start),
   .stage_trip(stage_trip), .stage_state(stage_state));

// ==== itf_front_end.sv ====
module itf_front_end (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic hit_req,
   input wire logic same_sign,
   output logic hit_ack,
   output logic sample_valid,
   output logic signed [15:0] residual_current,
   output logic signed [15:0] residual_voltage
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [1:0] div;
   // one sample every four clocks, a spike sample when asked; lines toggle between samples
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div <= 2'h0;
         hit_ack <= 1'b0;
         sample_valid <= 1'b0;
         residual_current <= 16'sh0000;
         residual_voltage <= 16'sh0000;
      end else begin
         div <= div + 2'h1;
         sample_valid <= (div == 2'h3);
         hit_ack <= (div == 2'h3) && hit_req;
         if (div == 2'h3) begin
            residual_current <= hit_req ? 16'sh0800 : 16'sh0000;
            residual_voltage <= (hit_req && !same_sign) ? -16'sh0100 : 16'sh0100;
         end else begin
            residual_current <= ~residual_current;
            residual_voltage <= ~residual_voltage;
         end
      end
   end
endmodule

// ==== itf_transient_stage_tb_top.sv ====
module itf_transient_stage_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sample_valid, rerr;
   logic stage_block, group_di, hit_req, same_sign, hit_ack, stage_start, stage_trip;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdat, rtc_date, rtc_time;
   logic signed [15:0] residual_current, residual_voltage;
   logic [15:0] fund_peak;
   logic [3:0] stage_state;
   logic [7:0] ra [7] = '{8'h00, 8'h08, 8'h40, 8'h44, 8'h48, 8'h4C, 8'h50};
   logic [31:0] rv [7] = '{32'h3, 32'h0, 32'h2, 32'hA0, 32'hC8, 32'h3C, 32'h2};
   int num_errors = 0;
   int comparisons = 0;

   itf_transient_stage #(.FORCE_MS(5)) u_itf_transient_stage (.pclk(pclk), .presetn(presetn),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .pready(pready), .prdata(prdata), .pslverr(pslverr), .sample_valid(sample_valid),
      .residual_current(residual_current), .residual_voltage(residual_voltage),
      .fund_peak(fund_peak), .stage_block(stage_block), .group_di(group_di),
      .rtc_date(rtc_date), .rtc_time(rtc_time), .stage_start(stage_start),
      .stage_trip(stage_trip), .stage_state(stage_state));
   itf_front_end u_itf_front_end (.pclk(pclk), .presetn(presetn), .hit_req(hit_req),
      .same_sign(same_sign), .hit_ack(hit_ack), .sample_valid(sample_valid),
      .residual_current(residual_current), .residual_voltage(residual_voltage));

   // 40 MHz clock and a running time of day
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   always @(posedge pclk) rtc_time <= rtc_time + 32'h1;

   task automatic close_out();
      $display("comparisons %0d errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic chk_rng(input string nm, input int lo, input int hi, input logic [31:0] got);
      comparisons++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         num_errors++;
         $display("mismatch %s expected %0d..%0d seen %h", nm, lo, hi, got);
      end
   endtask

   // one apb transfer; read data and error taken at the pready edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // one spike sample from the front end, then let the stage settle
   task automatic fire();
      hit_req <= 1'b1;
      do begin
         @(posedge pclk);
      end while (hit_ack !== 1'b1);
      hit_req <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask

   task automatic wait_ms(input int m);
      repeat (m * 32 / 5) @(posedge pclk);
   endtask

   task automatic chk_out(input logic [3:0] st, input logic trip);
      chk("state", {28'h0, st}, {28'h0, stage_state});
      chk("trip", {31'h0, trip}, {31'h0, stage_trip});
   endtask

   // watchdog
   initial begin
      repeat (14000) @(posedge pclk);
      num_errors++;
      close_out();
   end

   // main sequence
   initial begin
      {presetn, psel, penable, pwrite, stage_block, group_di, hit_req, same_sign} = 8'h00;
      {paddr, pwdata, rtc_date, rtc_time, fund_peak} = '0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int k = 0; k < 7; k++) begin
         apb(1'b0, ra[k], 32'h0);
         chk($sformatf("reset reg %h", ra[k]), rv[k], rdat);
      end
      apb(1'b0, 8'h30, 32'h0);
      chk("unmapped slverr", 32'h1, {31'h0, rerr});
      apb(1'b1, 8'h41, 32'h5);
      chk("misaligned slverr", 32'h1, {31'h0, rerr});
      apb(1'b1, 8'h40, 32'h14);
      apb(1'b0, 8'h40, 32'h0);
      chk("peaks kept", 32'h2, rdat);
      apb(1'b0, 8'h04, 32'h0);
      chk("err flag", 32'h1, {31'h0, rdat[4]});
      apb(1'b1, 8'h04, 32'h0);
      apb(1'b1, 8'h40, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      chk("peaks floor", 32'h2, rdat);
      apb(1'b1, 8'h40, 32'h4);
      apb(1'b1, 8'h44, 32'h28);
      apb(1'b0, 8'h44, 32'h0);
      chk("delay at bound", 32'h28, rdat);
      apb(1'b1, 8'h40, 32'h5);
      apb(1'b0, 8'h40, 32'h0);
      chk("peaks over bound", 32'h4, rdat);
      apb(1'b1, 8'h44, 32'hA0);
      apb(1'b1, 8'h40, 32'h2);
      apb(1'b1, 8'h00, 32'h13);
      apb(1'b0, 8'h04, 32'h0);
      chk("manual group", 32'h1, {31'h0, rdat[5]});
      group_di <= 1'b1;
      apb(1'b1, 8'h00, 32'h0B);
      apb(1'b0, 8'h04, 32'h0);
      chk("pin group", 32'h1, {31'h0, rdat[5]});
      group_di <= 1'b0;
      apb(1'b1, 8'h00, 32'h3);
      stage_block <= 1'b1;
      repeat (3) @(posedge pclk);
      chk_out(4'h2, 1'b0);
      stage_block <= 1'b0;
      repeat (3) @(posedge pclk);
      chk_out(4'h1, 1'b0);
      // spikes that must not start the stage
      apb(1'b1, 8'h00, 32'h1);
      fire();
      chk_out(4'h1, 1'b0);
      apb(1'b1, 8'h00, 32'h3);
      same_sign <= 1'b1;
      fire();
      chk_out(4'h1, 1'b0);
      same_sign <= 1'b0;
      fund_peak <= 16'h1000;
      fire();
      chk_out(4'h1, 1'b0);
      fund_peak <= 16'h0000;
      // two close peaks accumulate, then trip, hold and record
      fire();
      chk_out(4'h4, 1'b0);
      chk("start", 32'h1, {31'h0, stage_start});
      wait_ms(5);
      fire();
      apb(1'b0, 8'h0C, 32'h0);
      chk_rng("delay two peaks", 39, 44, rdat);
      apb(1'b0, 8'h04, 32'h0);
      chk("peak count", 32'h2, {27'h0, rdat[10:6]});
      wait_ms(90);
      chk_out(4'h4, 1'b0);
      wait_ms(35);
      chk_out(4'h8, 1'b1);
      wait_ms(106);
      chk_out(4'h8, 1'b1);
      wait_ms(45);
      chk_out(4'h1, 1'b0);
      apb(1'b1, 8'h10, 32'h0);
      apb(1'b0, 8'h20, 32'h0);
      chk("record info", 32'h264, {22'h0, rdat[9:0]});
      apb(1'b0, 8'h1C, 32'h0);
      chk("record maxima", 32'h01000800, rdat);
      // last peak after full delay trips at once
      fire();
      wait_ms(170);
      chk_out(4'h4, 1'b0);
      fire();
      chk_out(4'h8, 1'b1);
      wait_ms(280);
      chk_out(4'h1, 1'b0);
      // lone peak releases after intermittent time
      fire();
      wait_ms(190);
      chk_out(4'h4, 1'b0);
      wait_ms(20);
      chk_out(4'h1, 1'b0);
      apb(1'b1, 8'h48, 32'h32);
      fire();
      wait_ms(40);
      chk_out(4'h4, 1'b0);
      wait_ms(20);
      chk_out(4'h1, 1'b0);
      // 60 Hz sample spacing slows down the millisecond count
      apb(1'b1, 8'h00, 32'h23);
      fire();
      wait_ms(50);
      apb(1'b0, 8'h0C, 32'h0);
      chk_rng("delay at 60 Hz", 60, 63, rdat);
      // forced start drops itself after the timeout
      apb(1'b1, 8'h00, 32'h0);
      apb(1'b1, 8'h00, 32'h47);
      chk_out(4'h1, 1'b0);
      chk("forced start", 32'h1, {31'h0, stage_start});
      wait_ms(8);
      chk("force timeout", 32'h0, {31'h0, stage_start});
      apb(1'b0, 8'h00, 32'h0);
      chk("force cleared", 32'h3, rdat);
      close_out();
   end
endmodule
